//--- design/ubc_pkg.sv
// Constants shared by the up/down binary counter and its register slave
package ubc_pkg;
    // Counter geometry
    localparam int CNT_WIDTH = 4;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [3:0] CNT_MIN = 4'h0;
    localparam logic [3:0] CNT_RESET = 4'h0;

    // Register byte offsets
    localparam int ADDR_WIDTH = 4;
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] PRESET_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;

    // Control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b1;

    // Preset register fields
    localparam int PRESET_VAL_LSB = 0;
    localparam int PRESET_LOAD_BIT = 4;
    localparam logic [3:0] PRESET_VAL_RESET = 4'h0;

    // Status register fields
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_CARRY_BIT = 4;
    localparam int STAT_DIR_BIT = 5;
    localparam int STAT_WRAP_BIT = 6;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ubc_pkg

//--- design/ubc_count_core.sv
// Four-bit presettable up/down count state with look-ahead carry
`timescale 1ns/1ns
`default_nettype none
module ubc_count_core #(
    parameter int WIDTH = ubc_pkg::CNT_WIDTH
) (
    input wire logic clock, // System clock
    input wire logic rstN, // Synchronised reset, low active
    input wire logic loadN, // Synchronous load, low active
    input wire logic [WIDTH-1:0] presetData, // Value taken on load
    input wire logic countEnN, // Count enable, low active
    input wire logic carryGateEnN, // Count enable that also gates carry
    input wire logic upDown, // High counts up, low counts down
    output logic [WIDTH-1:0] count, // Present count
    output logic carryN // Ripple carry, low active
);
    logic [WIDTH-1:0] countR;
    logic [WIDTH-1:0] countNxt;
    logic atTerminal;

    // Next count: load wins, then count, else hold
    always_comb begin
        countNxt = countR;
        if (!loadN) begin
            countNxt = presetData;
        end else if (!countEnN && !carryGateEnN) begin
            if (upDown) begin
                countNxt = countR + {{(WIDTH-1){1'b0}}, 1'b1};
            end else begin
                countNxt = countR - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // All bits share one rising edge
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            countR <= ubc_pkg::CNT_RESET;
        end else begin
            countR <= countNxt;
        end
    end

    // Terminal state for the present direction
    assign atTerminal = upDown ? (countR == {WIDTH{1'b1}}) : (countR == {WIDTH{1'b0}});

    // Carry is combinational, gated only by the carry enable
    assign carryN = !(atTerminal && !carryGateEnN);
    assign count = countR;
endmodule : ubc_count_core
`default_nettype wire

//--- design/ubc_counter_top.sv
// Top of the cascadable up/down counter with its AXI4-Lite register slave
//
// Notes on behaviour
// - Count bits change only at the rising clock edge or on reset.
// - All four bits are clocked together, so outputs change at once.
// - Load low at an edge copies the preset and suppresses counting.
// - Any value from zero to fifteen can be preset.
// - With load high, count only when both enables are low.
// - With load high, no software load and either enable high, the count holds.
// - Direction high increments, direction low decrements.
// - Count wraps modulo sixteen in both directions.
// - Carry is low when gated and at fifteen up or zero down.
// - Only the carry-gating enable reaches the carry output.
// - Input changes reach the count only at the next rising edge.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ubc_counter_top #(
    parameter int WIDTH = ubc_pkg::CNT_WIDTH,
    parameter int ADDR_W = ubc_pkg::ADDR_WIDTH
) (
    input wire logic clock, // 25 MHz system clock
    input wire logic arst_n, // Asynchronous reset, low active
    // Counter pins
    input wire logic countEnableN, // Count enable, low active
    input wire logic carryGateEnableN, // Carry-gating enable, low active
    input wire logic loadN, // Synchronous load, low active
    input wire logic upDown, // High up, low down
    input wire logic [WIDTH-1:0] presetData, // Preset value, bit 0 first
    output logic countOutBit0, // Count bit 0
    output logic countOutBit1, // Count bit 1
    output logic countOutBit2, // Count bit 2
    output logic countOutBit3, // Count bit 3
    output logic rippleCarryOutN, // Ripple carry, low active
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    // Reset synchroniser
    logic rstSync1R;
    logic rstSync2R;
    logic rstN;

    // Write channel state
    logic awReadyR;
    logic wReadyR;
    logic awHeldR;
    logic wHeldR;
    logic [ADDR_W-1:0] awAddrR;
    logic [31:0] wDataR;
    logic [3:0] wStrbR;
    logic bValidR;
    logic [1:0] bRespR;

    // Read channel state
    logic arReadyR;
    logic rValidR;
    logic [31:0] rDataR;
    logic [1:0] rRespR;

    // Software registers
    logic runR;
    logic [WIDTH-1:0] swPresetR;
    logic swLoadR;
    logic wrapR;

    // Handshake terms
    logic awTake;
    logic wTake;
    logic bTake;
    logic arTake;
    logic rTake;
    logic awHave;
    logic wHave;
    logic doWrite;
    logic [ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrCtrl;
    logic wrPreset;
    logic wrStatus;
    logic wrHit;
    logic awHeldNxt;
    logic wHeldNxt;
    logic bValidNxt;
    logic rValidNxt;

    // Counter side terms
    logic effLoadN;
    logic effCountEnN;
    logic [WIDTH-1:0] effPreset;
    logic [WIDTH-1:0] count;
    logic carryN;
    logic wrapEvent;
    logic [31:0] readWord;
    logic readHit;

    // Release reset through two flops; first flop feeds only the second
    // Assertion stays asynchronous so the count clears without a running clock
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1R <= 1'b0;
            rstSync2R <= 1'b0;
        end else begin
            rstSync1R <= 1'b1;
            rstSync2R <= rstSync1R;
        end
    end
    assign rstN = rstSync2R;

    // Software load overrides the pins for one edge; run gates counting
    // Run low looks like a high count enable, so a load still lands
    assign effLoadN = loadN && !swLoadR;
    assign effPreset = swLoadR ? swPresetR : presetData;
    assign effCountEnN = countEnableN || !runR;

    // Count state and look-ahead carry
    // The core holds the only count flops; the pins read them directly
    ubc_count_core #(
        .WIDTH(WIDTH)
    ) u_core (
        .clock(clock),
        .rstN(rstN),
        .loadN(effLoadN),
        .presetData(effPreset),
        .countEnN(effCountEnN),
        .carryGateEnN(carryGateEnableN),
        .upDown(upDown),
        .count(count),
        .carryN(carryN)
    );

    // Count bits straight from the core flops
    assign countOutBit0 = count[0];
    assign countOutBit1 = count[1];
    assign countOutBit2 = count[2];
    assign countOutBit3 = count[3];

    // Carry passes through without a register
    // A flop here would delay the carry by one edge and break cascading
    assign rippleCarryOutN = carryN;

    // A counting edge taken while the carry is low wraps the count
    // Built from the pin's own carry term so the flag and a cascade agree
    assign wrapEvent = effLoadN && !effCountEnN && !carryN;

    // Write handshake terms
    // A write fires on the edge where both halves are present
    assign awTake = s_axi_awvalid && awReadyR;
    assign wTake = s_axi_wvalid && wReadyR;
    assign bTake = bValidR && s_axi_bready;
    assign awHave = awHeldR || awTake;
    assign wHave = wHeldR || wTake;
    assign doWrite = awHave && wHave && !bValidR;

    // Use freshly taken payload or the held copy
    // Address and data may arrive on different edges; either may wait
    assign wrAddr = awHeldR ? awAddrR : s_axi_awaddr;
    assign wrData = wHeldR ? wDataR : s_axi_wdata;
    assign wrStrb = wHeldR ? wStrbR : s_axi_wstrb;

    // Write address decode on word boundaries
    // Low address bits are ignored, so byte offsets alias to their word
    assign wrCtrl = doWrite && (wrAddr[ADDR_W-1:2] == ubc_pkg::CTRL_OFFSET[ADDR_W-1:2]);
    assign wrPreset = doWrite && (wrAddr[ADDR_W-1:2] == ubc_pkg::PRESET_OFFSET[ADDR_W-1:2]);
    assign wrStatus = doWrite && (wrAddr[ADDR_W-1:2] == ubc_pkg::STATUS_OFFSET[ADDR_W-1:2]);
    assign wrHit = wrCtrl || wrPreset || wrStatus;

    // Next state of the write channel
    // Held halves clear on the edge that performs the write
    assign awHeldNxt = doWrite ? 1'b0 : awHave;
    assign wHeldNxt = doWrite ? 1'b0 : wHave;
    assign bValidNxt = doWrite || (bValidR && !s_axi_bready);

    // Write address and data capture
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            awHeldR <= 1'b0;
            wHeldR <= 1'b0;
            awAddrR <= '0;
            wDataR <= 32'h0000_0000;
            wStrbR <= 4'h0;
        end else begin
            awHeldR <= awHeldNxt;
            wHeldR <= wHeldNxt;
            if (awTake) begin
                awAddrR <= s_axi_awaddr;
            end
            if (wTake) begin
                wDataR <= s_axi_wdata;
                wStrbR <= s_axi_wstrb;
            end
        end
    end

    // Each ready only while its own half is not held and no response waits
    // Keeps one write in flight; readies return the cycle after the response
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            awReadyR <= 1'b0;
            wReadyR <= 1'b0;
        end else begin
            awReadyR <= !awHeldNxt && !bValidNxt;
            wReadyR <= !wHeldNxt && !bValidNxt;
        end
    end

    // Write response, error on unmapped offset
    // Code returns to okay once taken so a stale error never reappears
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            bValidR <= 1'b0;
            bRespR <= ubc_pkg::RESP_OKAY;
        end else begin
            bValidR <= bValidNxt;
            if (doWrite) begin
                bRespR <= wrHit ? ubc_pkg::RESP_OKAY : ubc_pkg::RESP_SLVERR;
            end else if (bTake) begin
                bRespR <= ubc_pkg::RESP_OKAY;
            end
        end
    end

    // Control register: run bit gates the count enable
    // Only byte lane 0 carries fields; other lanes are ignored
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            runR <= ubc_pkg::CTRL_RUN_RESET;
        end else if (wrCtrl && wrStrb[0]) begin
            runR <= wrData[ubc_pkg::CTRL_RUN_BIT];
        end
    end

    // Preset register and one-edge software load pulse
    // Pulse clears itself, so a later write without the load bit cannot reload
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            swPresetR <= ubc_pkg::PRESET_VAL_RESET;
            swLoadR <= 1'b0;
        end else begin
            swLoadR <= 1'b0;
            if (wrPreset && wrStrb[0]) begin
                swPresetR <= wrData[ubc_pkg::PRESET_VAL_LSB +: WIDTH];
                swLoadR <= wrData[ubc_pkg::PRESET_LOAD_BIT];
            end
        end
    end

    // Sticky wrap flag, write one to clear, a new wrap wins
    // Set has priority so a wrap in the clearing cycle is never lost
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            wrapR <= 1'b0;
        end else if (wrapEvent) begin
            wrapR <= 1'b1;
        end else if (wrStatus && wrStrb[0] && wrData[ubc_pkg::STAT_WRAP_BIT]) begin
            wrapR <= 1'b0;
        end
    end

    // Read handshake terms
    assign arTake = s_axi_arvalid && arReadyR;
    assign rTake = rValidR && s_axi_rready;
    assign rValidNxt = arTake || (rValidR && !s_axi_rready);

    // Read data selection
    // Sampled at the address edge; status shows the count before that edge
    always_comb begin
        readWord = 32'h0000_0000;
        readHit = 1'b1;
        if (s_axi_araddr[ADDR_W-1:2] == ubc_pkg::CTRL_OFFSET[ADDR_W-1:2]) begin
            readWord[ubc_pkg::CTRL_RUN_BIT] = runR;
        end else if (s_axi_araddr[ADDR_W-1:2] == ubc_pkg::PRESET_OFFSET[ADDR_W-1:2]) begin
            readWord[ubc_pkg::PRESET_VAL_LSB +: WIDTH] = swPresetR;
        end else if (s_axi_araddr[ADDR_W-1:2] == ubc_pkg::STATUS_OFFSET[ADDR_W-1:2]) begin
            readWord[ubc_pkg::STAT_COUNT_LSB +: WIDTH] = count;
            readWord[ubc_pkg::STAT_CARRY_BIT] = carryN;
            readWord[ubc_pkg::STAT_DIR_BIT] = upDown;
            readWord[ubc_pkg::STAT_WRAP_BIT] = wrapR;
        end else begin
            readHit = 1'b0;
        end
    end

    // Read channel: one read in flight, data held until taken
    // Data and code return to zero after the handshake
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rValidR <= 1'b0;
            rDataR <= 32'h0000_0000;
            rRespR <= ubc_pkg::RESP_OKAY;
        end else begin
            rValidR <= rValidNxt;
            if (arTake) begin
                rDataR <= readWord;
                rRespR <= readHit ? ubc_pkg::RESP_OKAY : ubc_pkg::RESP_SLVERR;
            end else if (rTake) begin
                rDataR <= 32'h0000_0000;
                rRespR <= ubc_pkg::RESP_OKAY;
            end
        end
    end

    // Read address ready while no data waits
    // Drops in the cycle after an address is taken, so reads never overlap
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            arReadyR <= 1'b0;
        end else begin
            arReadyR <= !rValidNxt;
        end
    end

    // Bus outputs straight from flops
    // No output of the bus side passes through logic
    assign s_axi_awready = awReadyR;
    assign s_axi_wready = wReadyR;
    assign s_axi_bvalid = bValidR;
    assign s_axi_bresp = bRespR;
    assign s_axi_arready = arReadyR;
    assign s_axi_rvalid = rValidR;
    assign s_axi_rdata = rDataR;
    assign s_axi_rresp = rRespR;
endmodule : ubc_counter_top
`default_nettype wire

//--- bench/ubc_counter_checker.sv
// Assertions on the counter pins and bus handshakes
`timescale 1ns/1ns
`default_nettype none
module ubc_counter_checker #(
    parameter int WIDTH = 4
) (
    input wire logic clock, // Clock
    input wire logic arst_n, // Reset
    input wire logic countEnableN, // Enable
    input wire logic carryGateEnableN, // Gate
    input wire logic loadN, // Load
    input wire logic upDown, // Direction
    input wire logic [WIDTH-1:0] presetData, // Preset
    input wire logic countOutBit0, // Bit 0
    input wire logic countOutBit1, // Bit 1
    input wire logic countOutBit2, // Bit 2
    input wire logic countOutBit3, // Bit 3
    input wire logic rippleCarryOutN, // Carry
    input wire logic [3:0] s_axi_awaddr, // Bus
    input wire logic [31:0] s_axi_wdata, // Bus
    input wire logic s_axi_awvalid, // Bus
    input wire logic s_axi_awready, // Bus
    input wire logic s_axi_wvalid, // Bus
    input wire logic s_axi_wready, // Bus
    input wire logic s_axi_bvalid, // Bus
    input wire logic s_axi_arvalid, // Bus
    input wire logic s_axi_arready, // Bus
    input wire logic s_axi_rvalid // Bus
);
    logic [3:0] cnt;
    logic [2:0] settleCnt_r;
    logic live;
    logic wrEdge;
    logic runMirror_r;
    logic swLoadMirror_r;
    logic [3:0] swPresetMirror_r;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // Count word and settling window after reset
    assign cnt = {countOutBit3, countOutBit2, countOutBit1, countOutBit0};
    assign live = settleCnt_r >= 3'h3;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            settleCnt_r <= 3'h0;
        end else if (!live) begin
            settleCnt_r <= settleCnt_r + 3'h1;
        end
    end
    // Mirror of the run bit and the one-edge software load
    assign wrEdge = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            runMirror_r <= ubc_pkg::CTRL_RUN_RESET;
            swLoadMirror_r <= 1'b0;
            swPresetMirror_r <= ubc_pkg::PRESET_VAL_RESET;
        end else begin
            swLoadMirror_r <= 1'b0;
            if (wrEdge && s_axi_awaddr[3:2] == ubc_pkg::CTRL_OFFSET[3:2]) begin
                runMirror_r <= s_axi_wdata[ubc_pkg::CTRL_RUN_BIT];
            end
            if (wrEdge && s_axi_awaddr[3:2] == ubc_pkg::PRESET_OFFSET[3:2]) begin
                swLoadMirror_r <= s_axi_wdata[ubc_pkg::PRESET_LOAD_BIT];
                swPresetMirror_r <= s_axi_wdata[ubc_pkg::PRESET_VAL_LSB +: 4];
            end
        end
    end
    // Handshake steps
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_carry_level: assert property (rippleCarryOutN ==
        !(!carryGateEnableN && (upDown ? cnt == 4'hF : cnt == 4'h0)))
        else $error("carry level wrong");
    a_load_copy: assert property (live && !loadN |=> cnt == $past(presetData))
        else $error("load value wrong");
    a_count_up: assert property (live && loadN && !countEnableN
        && !carryGateEnableN && upDown && runMirror_r && !swLoadMirror_r
        |=> cnt == $past(cnt) + 4'h1)
        else $error("up step wrong");
    a_count_down: assert property (live && loadN && !countEnableN
        && !carryGateEnableN && !upDown && runMirror_r && !swLoadMirror_r
        |=> cnt == $past(cnt) - 4'h1)
        else $error("down step wrong");
    a_hold_inhibit: assert property (live && loadN
        && !swLoadMirror_r && (countEnableN || carryGateEnableN || !runMirror_r)
        |=> $stable(cnt))
        else $error("count moved while inhibited");
    a_soft_load: assert property (live && swLoadMirror_r
        |=> cnt == $past(swPresetMirror_r))
        else $error("software load value wrong");
    a_enable_no_carry: assert property ($changed(countEnableN) && $stable(cnt)
        && $stable(upDown) && $stable(carryGateEnableN) |-> $stable(rippleCarryOutN))
        else $error("carry followed count enable");
    a_write_answer: assert property (s_write_taken |=> s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : ubc_counter_checker
bind ubc_counter_top ubc_counter_checker #(.WIDTH(WIDTH)) ubc_counter_checker_inst (
    .clock, .arst_n, .countEnableN, .carryGateEnableN, .loadN, .upDown, .presetData,
    .countOutBit0, .countOutBit1, .countOutBit2, .countOutBit3, .rippleCarryOutN,
    .s_axi_awaddr, .s_axi_wdata,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);
`default_nettype wire

//--- bench/ubc_cascade_stage.sv
// Behavioural next cascade stage fed by the counter's ripple carry
`timescale 1ns/1ns
`default_nettype none
module ubc_cascade_stage (
    input wire logic clock, // Clock
    input wire logic arst_n, // Reset
    input wire logic carryInN, // Carry from below
    output logic [3:0] stageCount // Upper nibble
);
    // Carry low from below enables this stage for one edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stageCount <= 4'h0;
        end else if (!carryInN) begin
            stageCount <= stageCount + 4'h1;
        end
    end
endmodule : ubc_cascade_stage
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the up/down counter and its register slave
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin \
    $display("mismatch %s exp %0h got %0h", n, e, g); errTotal++; end end
module testbench;
    logic clock, arst_n, countEnableN, carryGateEnableN, loadN, upDown;
    logic [3:0] presetData, cntOut, stageCount, modelCnt, modelStage, awAddr, arAddr;
    logic b0, b1, b2, b3, carryN, modelWrap, modelRun;
    logic awV, awR, wV, wR, bV, bRdy, arV, arR, rV, rRdy;
    logic [31:0] wData, rData, rnd;
    logic [1:0] bResp, rResp;
    int errTotal = 0;
    int testsRun = 0;
    integer seed = 32'habc2;
    assign cntOut = {b3, b2, b1, b0};
    ubc_counter_top ubc_counter_top_inst (.clock, .arst_n, .countEnableN, .carryGateEnableN,
        .loadN, .upDown, .presetData, .countOutBit0(b0), .countOutBit1(b1),
        .countOutBit2(b2), .countOutBit3(b3), .rippleCarryOutN(carryN),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awV), .s_axi_awready(awR),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wR),
        .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arV), .s_axi_arready(arR),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rRdy));
    ubc_cascade_stage ubc_cascade_stage_inst (.clock, .arst_n, .carryInN(carryN), .stageCount);
    // Clock and watchdog
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        #400000;
        errTotal++;
        results();
    end
    function automatic logic carryExp();
        return !(!carryGateEnableN && (upDown ? modelCnt == 4'hF : modelCnt == 4'h0));
    endfunction : carryExp
    task automatic results();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // One edge: model takes the inputs seen by the design, then new inputs go out
    task automatic cyc(input logic ld, ce, ge, ud, input logic [3:0] p);
        @(posedge clock);
        if (!carryExp()) modelStage += 4'h1;
        if (!loadN) begin
            modelCnt = presetData;
        end else if (!countEnableN && !carryGateEnableN && modelRun) begin
            modelWrap |= !carryExp();
            modelCnt = upDown ? modelCnt + 4'h1 : modelCnt - 4'h1;
        end
        loadN <= ld;
        countEnableN <= ce;
        carryGateEnableN <= ge;
        upDown <= ud;
        presetData <= p;
        @(negedge clock);
        `CHK("count", modelCnt, cntOut);
        `CHK("carry", carryExp(), carryN);
        `CHK("stage", modelStage, stageCount);
    endtask : cyc
    // One bus write or read; for a read d is the expected data
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic [3:0] hs;
        logic [1:0] resp;
        logic [31:0] rd;
        @(posedge clock);
        if (wr) begin
            awAddr <= a;
            awV <= 1'b1;
            wData <= d;
            wV <= 1'b1;
            bRdy <= 1'b1;
        end else begin
            arAddr <= a;
            arV <= 1'b1;
            rRdy <= 1'b1;
        end
        for (int n = 0; n < 50; n++) begin
            @(negedge clock);
            hs = {awR, wR, arR, bV | rV};
            resp = wr ? bResp : rResp;
            rd = rData;
            @(posedge clock);
            if (hs[3]) awV <= 1'b0;
            if (hs[2]) wV <= 1'b0;
            if (hs[1]) arV <= 1'b0;
            if (hs[0]) begin
                bRdy <= 1'b0;
                rRdy <= 1'b0;
                `CHK("resp", er, resp);
                if (!wr) `CHK("rdata", d, rd);
                return;
            end
        end
        errTotal++;
        results();
    endtask : axi
    task automatic doReset(input int k);
        @(posedge clock);
        arst_n <= 1'b0;
        loadN <= 1'b1;
        countEnableN <= 1'b1;
        carryGateEnableN <= 1'b1;
        repeat (k) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        modelCnt = 4'h0;
        modelStage = 4'h0;
        modelWrap = 1'b0;
        modelRun = 1'b1;
    endtask : doReset
    // Main sequence
    initial begin
        {arst_n, countEnableN, carryGateEnableN, loadN, upDown, presetData} = 9'h0F0;
        {awAddr, arAddr, wData, awV, wV, bRdy, arV, rRdy} = '0;
        doReset(4);
        cyc(1'b0, 1'b1, 1'b1, 1'b1, 4'hD);
        repeat (5) cyc(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
        cyc(1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
        cyc(1'b1, 1'b0, 1'b1, 1'b1, 4'h0);
        repeat (5) cyc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
        for (int v = 0; v < 16; v++) cyc(1'b0, 1'b0, 1'b0, v[0], v[3:0]);
        repeat (40) cyc(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
        repeat (400) begin
            rnd = $random(seed);
            cyc(rnd[2:0] != 3'h0, rnd[3] & rnd[10], rnd[4] & rnd[11], rnd[5], rnd[9:6]);
        end
        cyc(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
        cyc(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
        // Register map: reset values, reserved bits, sticky clear, unmapped place
        axi(1'b0, ubc_pkg::CTRL_OFFSET, 32'h1, ubc_pkg::RESP_OKAY);
        axi(1'b0, ubc_pkg::PRESET_OFFSET, 32'h0, ubc_pkg::RESP_OKAY);
        axi(1'b1, ubc_pkg::PRESET_OFFSET, 32'hFFFF_FF0A, ubc_pkg::RESP_OKAY);
        axi(1'b0, ubc_pkg::PRESET_OFFSET, 32'hA, ubc_pkg::RESP_OKAY);
        axi(1'b0, ubc_pkg::STATUS_OFFSET, {25'h0, modelWrap, upDown, carryExp(), modelCnt},
            ubc_pkg::RESP_OKAY);
        axi(1'b1, ubc_pkg::STATUS_OFFSET, 32'h40, ubc_pkg::RESP_OKAY);
        axi(1'b0, ubc_pkg::STATUS_OFFSET, {26'h0, upDown, carryExp(), modelCnt},
            ubc_pkg::RESP_OKAY);
        axi(1'b1, 4'hC, 32'h1, ubc_pkg::RESP_SLVERR);
        axi(1'b0, 4'hC, 32'h0, ubc_pkg::RESP_SLVERR);
        // Run off: enables low must hold, a pin load still lands, then a software load
        axi(1'b1, ubc_pkg::CTRL_OFFSET, 32'h0, ubc_pkg::RESP_OKAY);
        modelRun = 1'b0;
        axi(1'b0, ubc_pkg::CTRL_OFFSET, 32'h0, ubc_pkg::RESP_OKAY);
        repeat (3) cyc(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
        cyc(1'b0, 1'b1, 1'b1, 1'b1, 4'h3);
        cyc(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
        axi(1'b1, ubc_pkg::PRESET_OFFSET, 32'h15, ubc_pkg::RESP_OKAY);
        modelCnt = 4'h5;
        cyc(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
        axi(1'b0, ubc_pkg::PRESET_OFFSET, 32'h5, ubc_pkg::RESP_OKAY);
        axi(1'b1, ubc_pkg::CTRL_OFFSET, 32'h1, ubc_pkg::RESP_OKAY);
        modelRun = 1'b1;
        // Second reset in mid-run, then count down through zero
        doReset(2);
        repeat (20) cyc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
        results();
    end
endmodule : testbench
`default_nettype wire
